// ---- core/elbr_params.svh ----
// constants for the event latch bus readout block
`ifndef ELBR_PARAMS_SVH
`define ELBR_PARAMS_SVH
// register offsets inside the module's 2 KB window
`define ELBR_OFF_CTRL 11'h000
`define ELBR_OFF_IRQVER 11'h004
`define ELBR_OFF_KEY_CLR 11'h030
`define ELBR_OFF_KEY_NEXT 11'h034
`define ELBR_OFF_KEY_NEXT_ON 11'h038
`define ELBR_OFF_KEY_NEXT_OFF 11'h03C
`define ELBR_OFF_FIFO_LO 11'h100
`define ELBR_OFF_FIFO_HI 11'h1FC
// control register set bits; the paired clear bit sits 8 above
`define ELBR_CFG_USER 0
`define ELBR_CFG_TEST 1
`define ELBR_CFG_MODE_LO 2
`define ELBR_CFG_MODE_HI 3
`define ELBR_CFG_BC_EN 6
`define ELBR_CFG_BC_HS 7
`define ELBR_CFG_CLR_LO 8
`define ELBR_CFG_CLR_HI 15
`define ELBR_IEN_SET_LO 20
`define ELBR_IEN_SET_HI 23
`define ELBR_IEN_CLR_LO 28
`define ELBR_IEN_CLR_HI 31
`define ELBR_CFG_RESET 8'h00
`define ELBR_IEN_RESET 4'h0
// interrupt and version register fields
`define ELBR_IRQ_GLOBAL 11
`define ELBR_IRQ_LVL_HI 10
`define ELBR_IRQ_LVL_LO 8
`define ELBR_IRQ_VEC_HI 7
`define ELBR_IRQ_VEC_LO 0
`define ELBR_IRQ_RESET 12'h000
// copy in progress delay after the next edge
`define ELBR_CIP_DELAY_NS 25
`define ELBR_CLK_PERIOD_NS 4
`define ELBR_CIP_CYCLES ((`ELBR_CIP_DELAY_NS + `ELBR_CLK_PERIOD_NS - 1) / `ELBR_CLK_PERIOD_NS)
`endif

// ---- core/elbr_pkg.sv ----
// types for the event latch bus readout block
package elbr_pkg;
  // bus cycle states, one-hot
  typedef enum logic [2:0] {
    ELBR_IDLE = 3'h1,
    ELBR_RESPOND = 3'h2,
    ELBR_IGNORE = 3'h4
  } elbr_bus_state_type;
  // control output routing modes
  typedef enum logic [1:0] {
    ELBR_MODE_STATUS = 2'h0,
    ELBR_MODE_PULSE6 = 2'h1,
    ELBR_MODE_FASTOR = 2'h2,
    ELBR_MODE_PULSER = 2'h3
  } elbr_mode_type;
endpackage

// ---- core/elbr_top.sv ----
// event fifo and backplane readout logic of the event latch
// How it works
// - any read in 0x100-0x1FC returns next word
// - test mode lets writes fill the fifo
// - upper address bits form broadcast class
// - broadcast needs bit 6; bit 7 answers
// - four broadcast keys at 0x30 to 0x3C
// - broadcast only in firmware version one
// - broadcast key 0x34 latches one event
// - broadcast key 0x30 clears fifo and logic
// - four sources: cip start, half, almost, full
// - 8-bit vector, released on acknowledge
// - per-source enable with set/clear pair
// - bus request needs global enable bit 11
// - internal interrupt flag readable by software
// - level bits 10:8, vector bits 7:0
// - D32 whole word; D16 high then low
// - mode 0: full, half, empty, cip
// - mode 1: full, half, pulser, cip
// - mode 2: fast or, user, pulser, cip
// - mode 3: pulser on controls 8, 7, 6, 5
// - mode 3: pulser on all four controls
// - cip at least 25 ns (7 clocks, 28 ns) after next until stored
`timescale 1ns/1ns
`default_nettype none
`include "elbr_params.svh"

// word fifo; depth must be a power of two so the pointers wrap freely
module elbr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } elbr_fifo_state_type;
  elbr_fifo_state_type st_q, st_d;
  logic push, pop;

  assign in_ready = st_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_q.cnt != '0;
  assign out_data = st_q.mem[st_q.rd];
  assign count = st_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; a clear drops everything stored
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.wr = '0;
      st_d.rd = '0;
      st_d.cnt = '0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wr] = in_data;
        st_d.wr = st_q.wr + 1'b1;
      end
      if (pop) begin
        st_d.rd = st_q.rd + 1'b1;
      end
      if (push && !pop) begin
        st_d.cnt = st_q.cnt + 1'b1;
      end else if (pop && !push) begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // elbr_fifo

module elbr_top #(
  parameter int FW_VERSION = 1,
  parameter logic [15:0] MODULE_ID = 16'h5A5A, // arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [31:0] bus_addr,
  input wire logic bus_a32,
  input wire logic bus_as_b,
  input wire logic bus_ds_b,
  input wire logic bus_write_b,
  input wire logic bus_lword_b,
  input wire logic bus_iack_b,
  input wire logic [2:0] bus_iack_level,
  input wire logic [31:0] bus_data_i,
  output logic [31:0] bus_data_o,
  output logic bus_data_oe,
  output logic bus_dtack_b_o,
  output logic bus_dtack_oe,
  output logic [6:0] bus_irq_b_o,
  output logic [6:0] bus_irq_oe,
  input wire logic [7:0] top_address_switch,
  input wire logic [3:0] upper_mid_address_switch,
  input wire logic [3:0] lower_mid_address_switch,
  input wire logic [3:0] a16_address_switch,
  input wire logic a11_jumper,
  input wire logic [31:0] data_in,
  input wire logic ext_next,
  input wire logic pulser_in,
  output logic [3:0] ctrl_out
);
  localparam int SW = 127;
  localparam int CW = $clog2(FIFO_DEPTH);
  typedef struct packed {
    logic [SW-1:0] sy1;
    logic [SW-1:0] sy2;
    elbr_pkg::elbr_bus_state_type st;
    logic [31:0] rdata;
    logic rd;
    logic dtack;
    logic half;
    logic [7:0] cfg;
    logic [3:0] ien;
    logic [11:0] irq;
    logic cip_flag;
    logic acked;
    logic next_en;
    logic next_prev;
    logic wait_cip;
    logic [3:0] cnt;
    logic copy_in_progress;
    logic [31:0] ev_word;
  } elbr_state_type;
  elbr_state_type st_q, st_d;

  logic [7:0] s_top;
  logic [3:0] s_um, s_lm, s_a16;
  logic s_a11, s_a32, s_iack_b, s_as_b, s_ds_b, s_write_b, s_lword_b, s_next;
  logic [2:0] s_ilvl;
  logic [31:0] s_adr, s_wd, s_din;
  logic [10:0] off;
  logic own_hit, bc_class, key_hit, bcast_hit, fifo_win, cyc_start;
  logic f_in_ready, f_out_valid, f_empty, f_half, f_almost, f_full;
  logic [31:0] f_out_data, f_in_data;
  logic [CW:0] f_count;
  logic [3:0] irq_cond;
  logic [2:0] irq_lvl;
  logic pending, irq_req, ev_push, test_push, rd_pop, fifo_clr, soft_next, ev_start;
  elbr_pkg::elbr_mode_type mode;

  // every pin except pulser_in crosses two flops; only the second stage is unpacked
  assign {s_top, s_um, s_lm, s_a16, s_a11, s_a32, s_ilvl, s_iack_b, s_as_b, s_ds_b,
          s_write_b, s_lword_b, s_next, s_adr, s_wd, s_din} = st_q.sy2;

  // address decode; broadcast class leaves the a16 switch and a11 bits at zero
  assign off = s_adr[10:0];
  assign own_hit = s_a32 ? (s_adr[31:11] == {s_top, s_um, s_lm, s_a16, s_a11})
                         : (s_adr[23:11] == {s_um, s_lm, s_a16, s_a11});
  assign bc_class = (s_adr[15:11] == 5'h00) && (s_a32 ? (s_adr[31:16] == {s_top, s_um, s_lm})
                                                      : (s_adr[23:16] == {s_um, s_lm}));
  assign key_hit = (off >= `ELBR_OFF_KEY_CLR) && (off <= `ELBR_OFF_KEY_NEXT_OFF)
                   && (off[1:0] == 2'h0);
  assign bcast_hit = (FW_VERSION == 1) && st_q.cfg[`ELBR_CFG_BC_EN] && bc_class && key_hit
                     && !s_write_b && !own_hit;
  assign fifo_win = (off >= `ELBR_OFF_FIFO_LO) && (off <= `ELBR_OFF_FIFO_HI);
  assign cyc_start = (st_q.st == elbr_pkg::ELBR_IDLE) && !s_as_b && !s_ds_b;

  // fifo status levels; almost full is one word short of full
  assign f_empty = !f_out_valid;
  assign f_full = !f_in_ready;
  assign f_half = f_count >= (CW+1)'(FIFO_DEPTH / 2);
  assign f_almost = f_count >= (CW+1)'(FIFO_DEPTH - 1);

  // interrupt sources gated by their enables and the global bit
  assign irq_cond = {f_full, f_almost, f_half, st_q.cip_flag};
  assign pending = |(irq_cond & st_q.ien);
  assign irq_lvl = st_q.irq[`ELBR_IRQ_LVL_HI:`ELBR_IRQ_LVL_LO];
  assign irq_req = st_q.irq[`ELBR_IRQ_GLOBAL] && pending && !st_q.acked
                   && (irq_lvl != 3'h0);
  assign bus_irq_oe = irq_req ? (7'h01 << (irq_lvl - 3'h1)) : 7'h00;
  assign bus_irq_b_o = 7'h00;

  // backplane drivers come straight from flops
  assign bus_data_o = st_q.rdata;
  assign bus_data_oe = (st_q.st == elbr_pkg::ELBR_RESPOND) && st_q.rd;
  assign bus_dtack_oe = (st_q.st == elbr_pkg::ELBR_RESPOND) && st_q.dtack;
  assign bus_dtack_b_o = 1'b0;

  // a latched event has priority over test writes for the fifo input
  assign ev_push = st_q.copy_in_progress && f_in_ready;
  assign f_in_data = st_q.copy_in_progress ? st_q.ev_word : s_wd;

  // control output routing, index 0 is control 5
  assign mode = elbr_pkg::elbr_mode_type'(st_q.cfg[`ELBR_CFG_MODE_HI:`ELBR_CFG_MODE_LO]);
  always_comb begin
    unique case (mode)
      elbr_pkg::ELBR_MODE_STATUS: ctrl_out = {f_full, f_half, f_empty, st_q.copy_in_progress};
      elbr_pkg::ELBR_MODE_PULSE6: ctrl_out = {f_full, f_half, pulser_in, st_q.copy_in_progress};
      elbr_pkg::ELBR_MODE_FASTOR: ctrl_out = {|s_din, st_q.cfg[`ELBR_CFG_USER],
                                              pulser_in, st_q.copy_in_progress};
      elbr_pkg::ELBR_MODE_PULSER: ctrl_out = {4{pulser_in}};
    endcase
  end

  elbr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(fifo_clr),
    .in_valid(ev_push || test_push),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(rd_pop),
    .out_data(f_out_data),
    .count(f_count)
  );

  // bus cycle handling, key commands and the event latch
  always_comb begin
    st_d = st_q;
    test_push = 1'b0;
    rd_pop = 1'b0;
    fifo_clr = 1'b0;
    soft_next = 1'b0;
    st_d.sy1 = {top_address_switch, upper_mid_address_switch, lower_mid_address_switch,
                a16_address_switch, a11_jumper, bus_a32, bus_iack_level, bus_iack_b, bus_as_b,
                bus_ds_b, bus_write_b, bus_lword_b, ext_next, bus_addr, bus_data_i, data_in};
    st_d.sy2 = st_q.sy1;
    unique case (st_q.st)
      elbr_pkg::ELBR_IDLE: begin
        if (cyc_start) begin
          st_d.st = elbr_pkg::ELBR_RESPOND;
          st_d.dtack = 1'b1;
          st_d.rd = s_write_b;
          st_d.rdata = 32'h0000_0000;
          if (!s_iack_b) begin
            // answer only our own level, then drop the request
            if (irq_req && (s_ilvl == irq_lvl)) begin
              st_d.rdata = {24'h00_0000, st_q.irq[`ELBR_IRQ_VEC_HI:`ELBR_IRQ_VEC_LO]};
              st_d.rd = 1'b1;
              st_d.acked = 1'b1;
            end else begin
              st_d.st = elbr_pkg::ELBR_IGNORE;
            end
          end else if (own_hit && s_write_b) begin
            if (off == `ELBR_OFF_CTRL) begin
              st_d.rdata = {8'h00, st_q.ien, irq_cond, 1'b0, st_q.next_en, pending, st_q.copy_in_progress,
                            f_full, f_almost, f_half, f_empty, st_q.cfg};
            end else if (off == `ELBR_OFF_IRQVER) begin
              st_d.rdata = {MODULE_ID, 4'(FW_VERSION), st_q.irq};
            end else if (fifo_win && !s_lword_b) begin
              st_d.rdata = f_out_data;
              rd_pop = 1'b1;
            end else if (fifo_win) begin
              // 16-bit pairs: high half first, the low half read pops the word
              st_d.rdata = {16'h0000, st_q.half ? f_out_data[15:0] : f_out_data[31:16]};
              rd_pop = st_q.half;
              st_d.half = !st_q.half;
            end
          end else if (own_hit) begin
            if (off == `ELBR_OFF_CTRL) begin
              st_d.cfg = (st_q.cfg | s_wd[7:0])
                         & ~s_wd[`ELBR_CFG_CLR_HI:`ELBR_CFG_CLR_LO];
              st_d.ien = (st_q.ien | s_wd[`ELBR_IEN_SET_HI:`ELBR_IEN_SET_LO])
                         & ~s_wd[`ELBR_IEN_CLR_HI:`ELBR_IEN_CLR_LO];
            end else if (off == `ELBR_OFF_IRQVER) begin
              st_d.irq = s_wd[11:0];
            end else if (fifo_win && st_q.cfg[`ELBR_CFG_TEST]) begin
              // wait for room and a quiet event path; the master sees a late dtack
              if (f_in_ready && !st_q.copy_in_progress) begin
                test_push = 1'b1;
              end else begin
                st_d.st = elbr_pkg::ELBR_IDLE;
                st_d.dtack = 1'b0;
              end
            end
          end else if (!bcast_hit) begin
            st_d.st = elbr_pkg::ELBR_IGNORE;
          end else if (!st_q.cfg[`ELBR_CFG_BC_HS]) begin
            // only the handshake controller answers a broadcast
            st_d.st = elbr_pkg::ELBR_IGNORE;
          end
          // key commands, individually or by broadcast
          if (s_iack_b && !s_write_b && key_hit && (own_hit || bcast_hit)) begin
            unique case (off)
              `ELBR_OFF_KEY_CLR: fifo_clr = 1'b1;
              `ELBR_OFF_KEY_NEXT: soft_next = 1'b1;
              `ELBR_OFF_KEY_NEXT_ON: st_d.next_en = 1'b1;
              `ELBR_OFF_KEY_NEXT_OFF: st_d.next_en = 1'b0;
              default: st_d.next_en = st_q.next_en;
            endcase
          end
        end
      end
      elbr_pkg::ELBR_RESPOND, elbr_pkg::ELBR_IGNORE: begin
        if (s_ds_b) begin
          st_d.st = elbr_pkg::ELBR_IDLE;
          st_d.dtack = 1'b0;
          st_d.rd = 1'b0;
        end
      end
      default: st_d.st = elbr_pkg::ELBR_IDLE;
    endcase

    // release-on-acknowledge: re-arm once nothing is pending any more
    if (!pending && !st_d.acked) begin
      st_d.acked = 1'b0;
    end else if (!pending) begin
      st_d.acked = 1'b0;
    end

    // event latch; a next during a copy is dead time and is dropped
    st_d.next_prev = s_next;
    ev_start = ((s_next && !st_q.next_prev) || soft_next) && st_q.next_en
               && !st_q.wait_cip && !st_q.copy_in_progress && !fifo_clr;
    if (fifo_clr) begin
      st_d.wait_cip = 1'b0;
      st_d.copy_in_progress = 1'b0;
      st_d.half = 1'b0;
    end else if (ev_start) begin
      st_d.ev_word = s_din;
      st_d.wait_cip = 1'b1;
      st_d.cnt = 4'(`ELBR_CIP_CYCLES - 1);
    end else if (st_q.wait_cip) begin
      st_d.cnt = st_q.cnt - 4'h1;
      if (st_q.cnt == 4'h1) begin
        st_d.wait_cip = 1'b0;
        st_d.copy_in_progress = 1'b1;
      end
    end else if (ev_push) begin
      st_d.copy_in_progress = 1'b0;
    end

    // start-of-copy flag: a new start beats the clear by disabling
    if (!st_q.ien[0]) begin
      st_d.cip_flag = 1'b0;
    end
    if (st_d.copy_in_progress && !st_q.copy_in_progress) begin
      st_d.cip_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= '0;
      // sync stages start at idle pin levels, so no false cycle or next edge follows reset
      st_q.sy1 <= '1;
      st_q.sy2 <= '1;
      st_q.next_prev <= 1'b1;
      st_q.st <= elbr_pkg::ELBR_IDLE;
      st_q.cfg <= `ELBR_CFG_RESET;
      st_q.ien <= `ELBR_IEN_RESET;
      st_q.irq <= `ELBR_IRQ_RESET;
      st_q.next_en <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  AST_BCAST_NEEDS_EN: assert property (@(posedge core_clk) disable iff (!rst_b)
    bcast_hit |-> st_q.cfg[`ELBR_CFG_BC_EN] && FW_VERSION == 1)
    else $error("broadcast decoded while not allowed");
  AST_BCAST_HANDSHAKE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cyc_start && s_iack_b && bcast_hit && !st_q.cfg[`ELBR_CFG_BC_HS]) |=> !bus_dtack_oe)
    else $error("non controller answered a broadcast");
  AST_TEST_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
    test_push |-> st_q.cfg[`ELBR_CFG_TEST] && fifo_win && !s_write_b)
    else $error("fifo write outside test mode");
  AST_POP_ON_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
    rd_pop |-> cyc_start && fifo_win && s_write_b && own_hit)
    else $error("fifo popped without a window read");
  AST_D16_HIGH_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cyc_start && s_iack_b && own_hit && s_write_b && fifo_win
     && s_lword_b && !st_q.half && f_out_valid && !st_q.copy_in_progress)
    |=> st_q.half && st_q.rdata[15:0] == $past(f_out_data[31:16]))
    else $error("16-bit read did not start with the high half");
  AST_CIP_DELAY: assert property (@(posedge core_clk) disable iff (!rst_b)
    ev_start |=> !st_q.copy_in_progress[*6] ##1 st_q.copy_in_progress)
    else $error("copy in progress not raised seven cycles after next");
  AST_CIP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q.copy_in_progress && !ev_push && !fifo_clr) |=> st_q.copy_in_progress)
    else $error("copy in progress dropped before the word was stored");
  AST_IRQ_GLOBAL: assert property (@(posedge core_clk) disable iff (!rst_b)
    (bus_irq_oe != 7'h00) |-> st_q.irq[`ELBR_IRQ_GLOBAL] && pending)
    else $error("interrupt driven without global enable");
  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_b)
    (bus_irq_oe != 7'h00) |-> bus_irq_oe == (7'h01 << (irq_lvl - 3'h1)))
    else $error("interrupt on the wrong level line");
  AST_IRQ_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cyc_start && !s_iack_b && irq_req && s_ilvl == irq_lvl)
    |=> bus_irq_oe == 7'h00 && bus_data_oe)
    else $error("request not released on acknowledge");
  AST_MODE_PULSER: assert property (@(posedge core_clk) disable iff (!rst_b)
    mode == elbr_pkg::ELBR_MODE_PULSER |-> ctrl_out == {4{pulser_in}})
    else $error("pulser mode did not drive all controls");

  COV_BCAST: cover property (@(posedge core_clk) disable iff (!rst_b) cyc_start && bcast_hit);
  COV_D16_PAIR: cover property (@(posedge core_clk) disable iff (!rst_b)
    rd_pop && s_lword_b);
  COV_IRQ_ACK: cover property (@(posedge core_clk) disable iff (!rst_b)
    cyc_start && !s_iack_b && irq_req);
  COV_FIFO_FULL: cover property (@(posedge core_clk) disable iff (!rst_b) f_full && st_q.copy_in_progress);
endmodule // elbr_top
`default_nettype wire

// ---- sim/elbr_master_model.sv ----
// backplane master model that runs single bus cycles against the readout block
`timescale 1ns/1ns
`default_nettype none
module elbr_master_model (
  input wire logic core_clk,
  output logic [31:0] bus_addr,
  output logic bus_as_b,
  output logic bus_ds_b,
  output logic bus_write_b,
  output logic bus_lword_b,
  output logic bus_iack_b,
  output logic [2:0] bus_iack_level,
  output logic [31:0] bus_data_i,
  input wire logic [31:0] bus_data_o,
  input wire logic dtack_b
);
  // idle bus: strobes high, address and data lines not meaningful
  initial begin
    bus_addr = 32'hFFFF_FFFF;
    bus_as_b = 1'b1;
    bus_ds_b = 1'b1;
    bus_write_b = 1'b1;
    bus_lword_b = 1'b0;
    bus_iack_b = 1'b1;
    bus_iack_level = 3'h3;
    bus_data_i = 32'hFFFF_FFFF;
  end
  // one cycle; ok stays low when no acknowledge comes within 64 clocks
  task automatic cyc(input logic ia, input logic wr, input logic w16, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    @(posedge core_clk);
    bus_addr <= a;
    bus_data_i <= d;
    bus_write_b <= !wr;
    bus_lword_b <= w16;
    bus_iack_b <= !ia;
    // address settles one clock ahead of the strobes
    @(posedge core_clk);
    bus_as_b <= 1'b0;
    bus_ds_b <= 1'b0;
    n = 0;
    ok = 1'b0;
    while (n < 64 && !ok) begin
      @(posedge core_clk);
      n++;
      ok = (dtack_b === 1'b0);
    end
    q = bus_data_o;
    // strobes rise after the acknowledge edge, or after the 64-clock timeout when none comes
    bus_as_b <= 1'b1;
    bus_ds_b <= 1'b1;
    n = 0;
    while (n < 64 && dtack_b !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    // released lines show the inverse so stale values cannot pass
    bus_addr <= ~a;
    bus_data_i <= ~d;
    bus_iack_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
endmodule // elbr_master_model
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the event latch readout block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module tb;
  localparam logic [31:0] BASE = 32'h3200_1000;
  int miscompares = 0;
  int total_checks = 0;
  logic core_clk, rst_b, bus_a32, ext_next, pulser_in, ok;
  logic bus_as_b, bus_ds_b, bus_write_b, bus_lword_b, bus_iack_b;
  logic bus_data_oe, bus_dtack_b_o, bus_dtack_oe, dtack_b;
  logic [2:0] bus_iack_level;
  logic [6:0] bus_irq_oe;
  logic [3:0] ctrl_out;
  logic [31:0] bus_addr, bus_data_i, bus_data_o, data_in, q;
  // open-drain acknowledge with a pull-up
  assign dtack_b = bus_dtack_oe ? bus_dtack_b_o : 1'b1;
  elbr_top i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_a32(bus_a32),
    .bus_as_b(bus_as_b), .bus_ds_b(bus_ds_b), .bus_write_b(bus_write_b),
    .bus_lword_b(bus_lword_b), .bus_iack_b(bus_iack_b), .bus_iack_level(bus_iack_level),
    .bus_data_i(bus_data_i), .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe),
    .bus_dtack_b_o(bus_dtack_b_o), .bus_dtack_oe(bus_dtack_oe), .bus_irq_b_o(),
    .bus_irq_oe(bus_irq_oe), .top_address_switch(8'h32), .upper_mid_address_switch(4'h0),
    .lower_mid_address_switch(4'h0), .a16_address_switch(4'h1), .a11_jumper(1'b0),
    .data_in(data_in), .ext_next(ext_next), .pulser_in(pulser_in), .ctrl_out(ctrl_out)
  );
  elbr_master_model i_master (
    .core_clk(core_clk), .bus_addr(bus_addr), .bus_as_b(bus_as_b), .bus_ds_b(bus_ds_b),
    .bus_write_b(bus_write_b), .bus_lword_b(bus_lword_b), .bus_iack_b(bus_iack_b),
    .bus_iack_level(bus_iack_level), .bus_data_i(bus_data_i), .bus_data_o(bus_data_o),
    .dtack_b(dtack_b)
  );
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_master.cyc(1'b0, 1'b1, 1'b0, BASE | a, d, q, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd(input logic [31:0] a, input logic w16);
    i_master.cyc(1'b0, 1'b0, w16, BASE | a, 32'h0, q, ok);
    `CHK(ok, 1'b1)
  endtask
  // bounded wait for an event to land in the fifo (empty on control 6 drops)
  task automatic wait_word();
    int n;
    n = 0;
    while (n < 64 && ctrl_out[1] !== 1'b0) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    bus_a32 = 1'b1;
    ext_next = 1'b0;
    pulser_in = 1'b0;
    data_in = 32'h0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(ctrl_out, 4'h2)
    `CHK({bus_data_oe, bus_dtack_oe, bus_irq_oe}, 9'h000)
    rd(32'h0, 1'b0);
    `CHK(q, 32'h0000_4100)
    rd(32'h4, 1'b0);
    `CHK(q, 32'h5A5A_1000)
    $display("test reset done");
    // test mode writes, reads at any window address, in order
    wr(32'h0, 32'h0000_0002);
    wr(32'h100, 32'hA0B1_C2D0);
    wr(32'h104, 32'hA0B1_C2D1);
    wr(32'h1FC, 32'hA0B1_C2D2);
    rd(32'h1FC, 1'b0);
    `CHK(q, 32'hA0B1_C2D0)
    rd(32'h100, 1'b0);
    `CHK(q, 32'hA0B1_C2D1)
    rd(32'h180, 1'b0);
    `CHK(q, 32'hA0B1_C2D2)
    wr(32'h100, 32'h1234_5678);
    rd(32'h100, 1'b1);
    `CHK(q[15:0], 16'h1234)
    rd(32'h100, 1'b1);
    `CHK(q[15:0], 16'h5678)
    // incrementing reads from the bottom of the window, as a block master would
    for (int i = 0; i < 4; i++) wr(32'h100 + 4 * i, 32'hB000_0000 + i);
    for (int i = 0; i < 4; i++) begin
      rd(32'h100 + 4 * i, 1'b0);
      `CHK(q, 32'hB000_0000 + i)
    end
    `CHK(ctrl_out[1], 1'b1)
    $display("test fifo done");
    // full source enabled, global enable still off
    wr(32'h4, 32'h0000_03A5);
    wr(32'h0, 32'h0080_0000);
    for (int i = 0; i < 8; i++) wr(32'h100, 32'h1111_0000 + i);
    repeat (4) @(posedge core_clk);
    `CHK(ctrl_out, 4'hC)
    `CHK(bus_irq_oe, 7'h00)
    rd(32'h0, 1'b0);
    `CHK(q[13], 1'b1)
    `CHK(q[19:17], 3'h7)
    wr(32'h4, 32'h0000_0BA5);
    repeat (3) @(posedge core_clk);
    `CHK(bus_irq_oe, 7'h04)
    i_master.cyc(1'b1, 1'b0, 1'b0, 32'h0, 32'h0, q, ok);
    `CHK(ok, 1'b1)
    `CHK(q[7:0], 8'hA5)
    repeat (3) @(posedge core_clk);
    `CHK(bus_irq_oe, 7'h00)
    wr(32'h0, 32'h8000_0000);
    rd(32'h0, 1'b0);
    `CHK(q[13], 1'b0)
    $display("test interrupt done");
    // output modes with the fifo full
    pulser_in <= 1'b1;
    wr(32'h0, 32'h0000_0004);
    `CHK(ctrl_out, 4'hE)
    wr(32'h0, 32'h0000_0008);
    `CHK(ctrl_out, 4'hF)
    pulser_in <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(ctrl_out, 4'h0)
    wr(32'h0, 32'h0000_0401);
    `CHK(ctrl_out, 4'h4)
    data_in <= 32'h0001_0000;
    repeat (4) @(posedge core_clk);
    `CHK(ctrl_out, 4'hC)
    wr(32'h30, 32'h0);
    rd(32'h0, 1'b0);
    `CHK(q[11:8], 4'h1)
    $display("test modes done");
    // broadcast next from the handshake controller
    data_in <= 32'hCAFE_0123;
    wr(32'h0, 32'h0000_3F00);
    wr(32'h0, 32'h0000_00C0);
    i_master.cyc(1'b0, 1'b1, 1'b0, 32'h3200_0034, 32'h0, q, ok);
    `CHK(ok, 1'b1)
    wait_word();
    rd(32'h100, 1'b0);
    `CHK(q, 32'hCAFE_0123)
    i_master.cyc(1'b0, 1'b1, 1'b0, 32'h3200_0034, 32'h0, q, ok);
    wait_word();
    `CHK(ctrl_out[1], 1'b0)
    bus_a32 <= 1'b0;
    i_master.cyc(1'b0, 1'b1, 1'b0, 32'h0000_0030, 32'h0, q, ok);
    `CHK(ok, 1'b1)
    repeat (4) @(posedge core_clk);
    `CHK(ctrl_out[1], 1'b1)
    bus_a32 <= 1'b1;
    wr(32'h0, 32'h0000_8000);
    i_master.cyc(1'b0, 1'b1, 1'b0, 32'h3200_0034, 32'h0, q, ok);
    `CHK(ok, 1'b0)
    $display("test broadcast done");
    complete_run();
  end
endmodule // tb
`default_nettype wire
